// File: hdl/pps_port_status.sv
// per-port status and control register bank of a three-port cable phy
`timescale 1ns/100ps
module pps_port_status
   import pps_pkg::*;
#(
   parameter int NP       = pps_pkg::NUM_PORTS,
   parameter int DEB_CYCS = pps_pkg::DEB_CYC,
   parameter logic [2:0] CAP_SPEED = 3'h3
) (
   // clock and reset
   input  wire logic                       CLK_I,
   input  wire logic                       RSTN_I,
   // register port
   input  wire logic [pps_pkg::ADDR_W-1:0] ADDR_I,
   input  wire logic [pps_pkg::DATA_W-1:0] WDATA_I,
   input  wire logic                       WR_I,
   input  wire logic                       RD_I,
   output logic      [pps_pkg::DATA_W-1:0] RDATA_O,
   // remote access read of the error counter, one pulse per port
   input  wire logic [NP-1:0]              REMOTE_ERR_RD_I,
   // port state from the cable front end (asynchronous)
   input  wire logic [NP-1:0]              CONN_RAW_I,
   input  wire logic [NP-1:0]              BETA_MODE_I,
   input  wire logic [NP-1:0]              BETA_SIGNAL_OK_I,
   input  wire logic [NP-1:0]              BIAS_OK_I,
   input  wire logic [NP-1:0]              STANDBY_I,
   // port events from core logic (same clock, one-cycle pulses)
   input  wire logic [NP-1:0]              NEG_FAIL_I,
   input  wire logic [NP-1:0]              BAD_CODEWORD_I,
   input  wire logic [NP-1:0]              LOOP_BLOCK_I,
   input  wire logic                       BUS_RESET_I,
   input  wire logic [NP-1:0]              NEW_BETA_CONN_I,
   // outputs to the port logic
   output logic [NP*pps_pkg::SPD_W-1:0]    TRAIN_SPEED_O,
   output logic [NP-1:0]                   PORT_ACTIVE_EN_O,
   output logic [NP-1:0]                   TONE_EN_O,
   output logic                            VENDOR_PAGE_O
);
   import pps_pkg::*;

   // synchronised front end levels
   logic [NP-1:0] conn_s, beta_s, sig_ok_s, bias_s, stby_s;
   pps_sync #(.W(5*NP)) u_sync (
      .clk_i  (CLK_I),
      .rstn_i (RSTN_I),
      .d_i    ({CONN_RAW_I, BETA_MODE_I, BETA_SIGNAL_OK_I, BIAS_OK_I,
                STANDBY_I}),
      .q_o    ({conn_s, beta_s, sig_ok_s, bias_s, stby_s})
   );

   // per-port state
   logic [2:0]    max_spd_r  [NP];
   logic [2:0]    train_r    [NP];
   logic [7:0]    err_cnt_r  [NP];
   logic [NP-1:0] unrel_r;
   logic [NP-1:0] loop_r;
   logic [NP-1:0] dis_r;
   logic [NP-1:0] hard_r;
   logic [NP-1:0] bonly_r;
   logic [NP-1:0] con_deb;
   logic [1:0]    port_sel_r;
   logic [2:0]    page_r;
   logic [7:0]    rdata_r;
   logic [7:0]    rdata_nxt;

   // register decode
   wire        port_page  = (page_r == PAGE_PORT);
   wire        vend_page  = (page_r == PAGE_VENDOR);
   wire        wr_sel     = WR_I && (ADDR_I == OFF_PORT_SEL);
   wire        wr_page    = WR_I && (ADDR_I == OFF_PAGE_SEL);
   wire        wr_speed   = WR_I && port_page && (ADDR_I == OFF_SPEED);
   wire        wr_flags   = WR_I && port_page && (ADDR_I == OFF_FLAGS);
   wire        wr_ctrl    = WR_I && port_page && (ADDR_I == OFF_CTRL);
   wire        rd_err     = RD_I && port_page && (ADDR_I == OFF_ERR_CNT);
   wire [2:0]  wr_spd_val = WDATA_I[SB_MAX +: SPD_W];
   wire [1:0]  ps         = port_sel_r;

   genvar g;
   generate
      for (g = 0; g < NP; g++) begin : g_port
         wire sel      = (ps == 2'(g));
         wire deep     = dis_r[g] & hard_r[g];
         wire err_clr  = (rd_err & sel) | REMOTE_ERR_RD_I[g];
         wire unrel_w1 = wr_flags & sel & WDATA_I[FB_UNREL];
         wire [2:0] req = pps_clamp(wr_spd_val, CAP_SPEED);
         wire req_ok   = (wr_spd_val < SPD_RSV_LO);

         pps_debounce #(.CYC(DEB_CYCS)) u_deb (
            .clk_i    (CLK_I),
            .rstn_i   (RSTN_I),
            .raw_i    (conn_s[g] & ~deep),
            .stable_o (con_deb[g])
         );

         always_ff @(posedge CLK_I or negedge RSTN_I) begin
            if (!RSTN_I) begin
               max_spd_r[g] <= CAP_SPEED;
               train_r[g]   <= SPD_BILING;
               err_cnt_r[g] <= ZERO_BYTE;
               unrel_r[g]   <= 1'b0;
               loop_r[g]    <= 1'b0;
               dis_r[g]     <= 1'b0;
               hard_r[g]    <= 1'b0;
               bonly_r[g]   <= 1'b0;
            end else begin
               // bilingual ports ignore speed writes
               if (wr_speed && sel && bonly_r[g] && req_ok)
                  max_spd_r[g] <= (req < SPD_MIN) ? SPD_MIN : req;
               // max speed applied on a beta-only port; s400 on a new beta link of a bilingual port
               if (bonly_r[g])
                  train_r[g] <= max_spd_r[g];
               else if (NEW_BETA_CONN_I[g])
                  train_r[g] <= SPD_BILING;
               // error counter; event set wins over read clear
               if (BAD_CODEWORD_I[g])
                  err_cnt_r[g] <= err_clr ? 8'h01 :
                     (err_cnt_r[g] == ERR_SAT ? ERR_SAT :
                      err_cnt_r[g] + 8'h01);
               else if (err_clr)
                  err_cnt_r[g] <= ZERO_BYTE;
               if (NEG_FAIL_I[g])
                  unrel_r[g] <= 1'b1;
               else if (unrel_w1)
                  unrel_r[g] <= 1'b0;
               if (LOOP_BLOCK_I[g])
                  loop_r[g] <= 1'b1;
               else if (BUS_RESET_I || !con_deb[g])
                  loop_r[g] <= 1'b0;
               if (wr_ctrl && sel) begin
                  dis_r[g]   <= WDATA_I[CB_DIS];
                  hard_r[g]  <= WDATA_I[CB_HARD];
                  bonly_r[g] <= WDATA_I[CB_BONLY];
               end
            end
         end

         assign TRAIN_SPEED_O[g*SPD_W +: SPD_W] = train_r[g];
         assign PORT_ACTIVE_EN_O[g] = ~dis_r[g];
         assign TONE_EN_O[g]        = ~deep;
      end
   endgenerate

   // selected-port view
   wire       con_v   = con_deb[ps];
   wire       deep_v  = dis_r[ps] & hard_r[ps];
   wire       port_receive_ok_flag_v  = ~deep_v & (beta_s[ps] ? sig_ok_s[ps]
                                              : bias_s[ps]);
   wire       beta_v  = beta_s[ps] & con_v;
   wire [7:0] flags_v = {1'b0, port_receive_ok_flag_v, con_v, stby_s[ps],
                         loop_r[ps], beta_v, unrel_r[ps], 1'b1};
   wire [7:0] speed_v = {1'b0, CAP_SPEED, 1'b0, max_spd_r[ps]};
   wire [7:0] ctrl_v  = {5'h00, bonly_r[ps], hard_r[ps], dis_r[ps]};

   always_comb begin
      rdata_nxt = ZERO_BYTE;
      if (ADDR_I == OFF_PORT_SEL)
         rdata_nxt = {6'h00, port_sel_r};
      else if (ADDR_I == OFF_PAGE_SEL)
         rdata_nxt = {5'h00, page_r};
      else if (vend_page && ADDR_I == OFF_VENDOR)
         rdata_nxt = VENDOR_ID_BYTE;
      else if (port_page) begin
         unique case (ADDR_I)
            OFF_SPEED:   rdata_nxt = speed_v;
            OFF_FLAGS:   rdata_nxt = flags_v;
            OFF_ERR_CNT: rdata_nxt = err_cnt_r[ps];
            OFF_CTRL:    rdata_nxt = ctrl_v;
            default:     rdata_nxt = ZERO_BYTE;
         endcase
      end
   end

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         port_sel_r <= 2'h0;
         page_r     <= PAGE_PORT;
         rdata_r    <= ZERO_BYTE;
      end else begin
         if (wr_sel && WDATA_I[1:0] < 2'(NP))
            port_sel_r <= WDATA_I[1:0];
         if (wr_page)
            page_r <= WDATA_I[PAGE_W-1:0];
         rdata_r <= RD_I ? rdata_nxt : ZERO_BYTE;
      end
   end

   assign RDATA_O       = rdata_r;
   assign VENDOR_PAGE_O = vend_page;

   // checks
   wire err_clr0 = (rd_err && ps == 2'h0) | REMOTE_ERR_RD_I[0];
   wire err_clr1 = (rd_err && ps == 2'h1) | REMOTE_ERR_RD_I[1];
   wire rd_flags = RD_I && port_page && (ADDR_I == OFF_FLAGS);

   chk_err_saturate: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      err_cnt_r[1] == ERR_SAT && BAD_CODEWORD_I[1] && !err_clr1
      |=> err_cnt_r[1] == ERR_SAT)
      else $error("error counter left saturation");
   chk_err_count_up: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      BAD_CODEWORD_I[0] && !err_clr0 && err_cnt_r[0] != ERR_SAT
      |=> err_cnt_r[0] == $past(err_cnt_r[0]) + 8'h01)
      else $error("error counter did not count");
   chk_err_clear: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      err_clr0 && !BAD_CODEWORD_I[0]
      |=> err_cnt_r[0] == ZERO_BYTE)
      else $error("error counter not cleared by read");

   chk_plug_one: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      $past(rd_flags)
      |-> RDATA_O[FB_PLUG])
      else $error("plug present flag read as zero");
   chk_beta_discon: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      $past(rd_flags) && !$past(con_v)
      |-> !RDATA_O[FB_BETA])
      else $error("beta flag shown on a disconnected port");
   chk_standby_flag: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      $past(rd_flags)
      |-> RDATA_O[FB_STANDBY] == $past(stby_s[ps]))
      else $error("standby flag does not follow the port");
   chk_port_receive_ok_flag_beta: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      $past(rd_flags) && $past(beta_s[ps]) && !$past(deep_v)
      |-> RDATA_O[FB_PORT_RECEIVE_OK_FLAG] == $past(sig_ok_s[ps]))
      else $error("receive ok does not follow valid signal");
   chk_deep_port_receive_ok_flag: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      $past(rd_flags) && $past(deep_v)
      |-> !RDATA_O[FB_PORT_RECEIVE_OK_FLAG])
      else $error("receive ok shown while deep disabled");

   chk_speed_clamp: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      max_spd_r[0] <= CAP_SPEED)
      else $error("max speed above capability");
   chk_speed_ignore: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      wr_speed && ps == 2'h0 && !bonly_r[0]
      |=> $stable(max_spd_r[0]))
      else $error("bilingual port took a speed write");
   chk_speed_rsv: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      wr_speed && ps == 2'h0 && wr_spd_val >= SPD_RSV_LO
      |=> $stable(max_spd_r[0]))
      else $error("reserved speed code stored");
   chk_cap_field: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      $past(RD_I) && $past(ADDR_I) == OFF_SPEED && $past(port_page)
      |-> RDATA_O[SB_CAP +: SPD_W] == CAP_SPEED)
      else $error("capability field wrong");
   chk_train_follow: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      bonly_r[0]
      |=> train_r[0] == $past(max_spd_r[0]))
      else $error("beta-only port does not train at max speed");
   chk_bilingual_s400: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      !bonly_r[2] && NEW_BETA_CONN_I[2]
      |=> train_r[2] == SPD_BILING)
      else $error("bilingual port not fixed at s400");

   chk_unrel_set: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      NEG_FAIL_I[0]
      |=> unrel_r[0])
      else $error("unreliable bit not set");
   chk_unrel_clear: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      wr_flags && ps == 2'h0 && WDATA_I[FB_UNREL] && !NEG_FAIL_I[0]
      |=> !unrel_r[0])
      else $error("unreliable bit not cleared by write");
   chk_loop_set: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      LOOP_BLOCK_I[0]
      |=> loop_r[0])
      else $error("loop blocked bit not set");
   chk_loop_clear: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      BUS_RESET_I && !LOOP_BLOCK_I[0]
      |=> !loop_r[0])
      else $error("loop blocked bit survived bus reset");
   chk_loop_discon: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      !con_deb[0] && !LOOP_BLOCK_I[0]
      |=> !loop_r[0])
      else $error("loop blocked bit survived disconnect");

   chk_deep_tone: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      dis_r[0] && hard_r[0]
      |-> !TONE_EN_O[0] ##1 !con_deb[0])
      else $error("deep disabled port still tones or connects");
   chk_tone_live: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      !dis_r[0]
      |-> TONE_EN_O[0])
      else $error("enabled port stopped toning");
   chk_active_dis: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      dis_r[0]
      |-> !PORT_ACTIVE_EN_O[0])
      else $error("disabled port may become active");
   chk_page_select: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      wr_page
      |=> vend_page == ($past(WDATA_I[PAGE_W-1:0]) == PAGE_VENDOR))
      else $error("page select write not applied");
   chk_vendor_map: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      $past(RD_I) && $past(ADDR_I) == OFF_VENDOR && $past(vend_page)
      |-> RDATA_O == VENDOR_ID_BYTE)
      else $error("vendor page not mapped");
   chk_page_hide: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      $past(RD_I) && $past(ADDR_I) == OFF_SPEED && !$past(port_page)
      |-> RDATA_O == ZERO_BYTE)
      else $error("port page visible on another page");
endmodule // pps_port_status

// File: pkg/pps_pkg.sv
// package: constants and types for the port status register block
package pps_pkg;

   localparam int NUM_PORTS  = 3;
   localparam int ADDR_W     = 4;
   localparam int DATA_W     = 8;
   localparam int SPD_W      = 3;
   localparam int ERR_W      = 8;
   localparam int PAGE_W     = 3;

   // speed encoding
   typedef enum logic [2:0] {
      PPS_S100  = 3'h0,
      PPS_S200  = 3'h1,
      PPS_S400  = 3'h2,
      PPS_S800  = 3'h3,
      PPS_S1600 = 3'h4,
      PPS_S3200 = 3'h5
   } pps_speed_t;

   localparam logic [2:0] SPD_RSV_LO  = 3'h6;
   localparam logic [2:0] SPD_MIN     = 3'h0;
   localparam logic [2:0] SPD_BILING  = 3'h2;

   // register offsets
   localparam logic [3:0] OFF_PORT_SEL  = 4'h0;
   localparam logic [3:0] OFF_PAGE_SEL  = 4'h7;
   localparam logic [3:0] OFF_SPEED     = 4'h8;
   localparam logic [3:0] OFF_FLAGS     = 4'h9;
   localparam logic [3:0] OFF_ERR_CNT   = 4'hA;
   localparam logic [3:0] OFF_CTRL      = 4'hB;
   localparam logic [3:0] OFF_VENDOR    = 4'hC;

   // flags register field positions
   localparam int FB_PLUG     = 0;
   localparam int FB_UNREL    = 1;
   localparam int FB_BETA     = 2;
   localparam int FB_LOOP     = 3;
   localparam int FB_STANDBY  = 4;
   localparam int FB_CON      = 5;
   localparam int FB_PORT_RECEIVE_OK_FLAG     = 6;

   // control register field positions
   localparam int CB_DIS      = 0;
   localparam int CB_HARD     = 1;
   localparam int CB_BONLY    = 2;

   // speed register field positions
   localparam int SB_MAX      = 0;
   localparam int SB_CAP      = 4;

   localparam logic [2:0] PAGE_PORT   = 3'h0;
   localparam logic [2:0] PAGE_VENDOR = 3'h1;

   localparam logic [7:0] ERR_SAT     = 8'hFF;
   localparam logic [7:0] ZERO_BYTE   = 8'h00;

   // connection debounce time
   localparam int DEB_MS      = 341;
   localparam int CLK_HZ      = 10_000_000;
   localparam longint DEB_CYC_L = longint'(DEB_MS) * CLK_HZ / 1000;
   localparam int DEB_CYC     = int'(DEB_CYC_L);

   // vendor page identity byte, arbitrary value
   localparam logic [7:0] VENDOR_ID_BYTE = 8'h5A;

   // clamps a requested speed to the capability
   function automatic logic [2:0] pps_clamp(input logic [2:0] req,
                                            input logic [2:0] cap);
      pps_clamp = (req > cap) ? cap : req;
   endfunction

endpackage

// File: hdl/pps_sync.sv
// two flip-flop synchroniser for a vector of levels
`timescale 1ns/100ps
module pps_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   // data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_r <= '0;
         q_r    <= '0;
      end else begin
         meta_r <= d_i;
         q_r    <= meta_r;
      end
   end

   assign q_o = q_r;
endmodule // pps_sync

// File: hdl/pps_debounce.sv
// connection debounce counter for one port
`timescale 1ns/100ps
module pps_debounce #(
   parameter int CYC = 3410000
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // raw and debounced level
   input  wire logic raw_i,
   output logic      stable_o
);
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic        stable_r;
   logic        stable_nxt;
   wire         done = (cnt_r >= 32'(CYC - 1));

   assign cnt_nxt    = !raw_i ? '0 : (done ? cnt_r : cnt_r + 32'h0000_0001);
   assign stable_nxt = raw_i & done;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_r    <= '0;
         stable_r <= 1'b0;
      end else begin
         cnt_r    <= cnt_nxt;
         stable_r <= stable_nxt;
      end
   end

   assign stable_o = stable_r;
endmodule // pps_debounce

// File: testbench/pps_link_model.sv
// link-layer controller model driving the register port
`timescale 1ns/100ps
module pps_link_model (
   // clock
   input  wire logic                       clk_i,
   // register port
   output logic      [pps_pkg::ADDR_W-1:0] addr_o,
   output logic      [pps_pkg::DATA_W-1:0] wdata_o,
   output logic                            wr_o,
   output logic                            rd_o,
   input  wire logic [pps_pkg::DATA_W-1:0] rdata_i
);
   import pps_pkg::*;

   initial begin
      addr_o  = '0;
      wdata_o = '0;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end

   // one-cycle write; data inverted once released
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge clk_i);
      wr_o    <= 1'b0;
      wdata_o <= ~d;
   endtask

   // one-cycle read, data taken in the following cycle
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clk_i);
      rd_o   <= 1'b0;
      #1;
      d = rdata_i;
   endtask

   // page 1 holds the vendor identification byte
   task automatic sel_page(input logic [2:0] pg);
      wr(OFF_PAGE_SEL, {5'h0, pg});
   endtask

   // lowering the speed never goes under the minimum code
   task automatic set_speed(input logic [2:0] s);
      wr(OFF_SPEED, {5'h0, (s < SPD_MIN) ? SPD_MIN : s});
   endtask

   // legacy active: connected, receive ok, not beta
   function automatic logic legacy_active(input logic [7:0] f);
      legacy_active = f[FB_CON] & f[FB_PORT_RECEIVE_OK_FLAG] & ~f[FB_BETA];
   endfunction
endmodule // pps_link_model

// File: testbench/phy_port_status_fields_bench.sv
// self-checking bench for the port status register bank
`timescale 1ns/100ps
`define CHK(nm, e, g) \
   begin \
      cmp_count++; \
      if ((g) !== (e)) begin \
         n_mismatch++; \
         $display("[ERR] %s exp %h got %h", nm, e, g); \
      end \
   end
module phy_port_status_fields_bench;
   import pps_pkg::*;
   localparam logic [2:0] CAP = 3'h3;
   logic       clk, rstn, wr, rd, vpage, busr;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, g;
   logic [2:0] rrd, conn, betam, betaok, bias, stby;
   logic [2:0] neg, bad, loopb, newb, act, tone, v;
   logic [8:0] train;
   int         n_mismatch, cmp_count, n, cyc;

   pps_port_status #(.DEB_CYCS(20), .CAP_SPEED(CAP)) pps_port_status_inst (
      .CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .REMOTE_ERR_RD_I(rrd),
      .CONN_RAW_I(conn), .BETA_MODE_I(betam), .BETA_SIGNAL_OK_I(betaok),
      .BIAS_OK_I(bias), .STANDBY_I(stby), .NEG_FAIL_I(neg),
      .BAD_CODEWORD_I(bad), .LOOP_BLOCK_I(loopb), .BUS_RESET_I(busr),
      .NEW_BETA_CONN_I(newb), .TRAIN_SPEED_O(train),
      .PORT_ACTIVE_EN_O(act), .TONE_EN_O(tone), .VENDOR_PAGE_O(vpage));

   pps_link_model pps_link_model_inst (
      .clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
      .rdata_i(rdata));

   function automatic logic [7:0] spd_reg(input logic [2:0] req);
      spd_reg = {1'b0, CAP, 1'b0, (req > CAP) ? CAP : req};
   endfunction

   task automatic rdc(input logic [3:0] a, input logic [7:0] e,
                      input string nm);
      pps_link_model_inst.rd(a, g);
      `CHK(nm, e, g)
   endtask

   // one-cycle event pulse on port p; k 3 pulses the bus reset, which is shared by all ports
   task automatic ev(input int k, input int p);
      @(posedge clk);
      case (k)
         0: neg[p] <= 1'b1;
         1: bad[p] <= 1'b1;
         2: loopb[p] <= 1'b1;
         3: busr <= 1'b1;
         4: rrd[p] <= 1'b1;
         default: newb[p] <= 1'b1;
      endcase
      @(posedge clk);
      {neg, bad, loopb, rrd, newb} <= '0;
      busr <= 1'b0;
   endtask

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   initial begin
      {rstn, busr, rrd, conn, betam, betaok, bias, stby} = '0;
      {neg, bad, loopb, newb} = '0;
      n = $urandom(32'hd686450d);
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      `CHK("train rst", 9'h092, train)
      rdc(OFF_SPEED, spd_reg(CAP), "speed rst");
      rdc(OFF_FLAGS, 8'h01, "flags rst");
      $display("test reset done");
      pps_link_model_inst.wr(OFF_SPEED, 8'h01);
      rdc(OFF_SPEED, spd_reg(CAP), "biling wr");
      pps_link_model_inst.wr(OFF_CTRL, 8'h04);
      for (int i = 0; i < 8; i++) begin
         v = (i == 0) ? 3'h5 : 3'($urandom_range(5, 0));
         pps_link_model_inst.set_speed(v);
         rdc(OFF_SPEED, spd_reg(v), "speed wr");
      end
      pps_link_model_inst.set_speed(3'h1);
      pps_link_model_inst.wr(OFF_SPEED, 8'h06);
      rdc(OFF_SPEED, spd_reg(3'h1), "speed rsv");
      `CHK("train p0", 3'h1, train[2:0])
      ev(5, 2);
      @(negedge clk);
      `CHK("train p2", 3'h2, train[8:6])
      pps_link_model_inst.wr(OFF_PORT_SEL, 8'h01);
      rdc(OFF_SPEED, spd_reg(CAP), "speed p1");
      $display("test speed done");
      repeat (260) ev(1, 1);
      rdc(OFF_ERR_CNT, ERR_SAT, "err sat");
      ev(1, 1);
      ev(4, 1);
      rdc(OFF_ERR_CNT, 8'h00, "err remote");
      pps_link_model_inst.wr(OFF_PORT_SEL, 8'h00);
      n = $urandom_range(20, 1);
      repeat (n) ev(1, 0);
      rdc(OFF_ERR_CNT, 8'(n), "err cnt");
      rdc(OFF_ERR_CNT, 8'h00, "err clr");
      $display("test errors done");
      @(posedge clk);
      conn[0] <= 1'b1;
      bias[0] <= 1'b1;
      repeat (30) @(posedge clk);
      rdc(OFF_FLAGS, 8'h61, "legacy");
      `CHK("leg act", 1'b1, pps_link_model_inst.legacy_active(g))
      @(posedge clk);
      {betam[0], betaok[0], bias[0], stby[0]} <= 4'b1101;
      repeat (4) @(posedge clk);
      rdc(OFF_FLAGS, 8'h75, "beta");
      ev(2, 0);
      rdc(OFF_FLAGS, 8'h7D, "loop set");
      ev(3, 0);
      rdc(OFF_FLAGS, 8'h75, "loop clr");
      ev(0, 0);
      rdc(OFF_FLAGS, 8'h77, "unrel set");
      pps_link_model_inst.wr(OFF_FLAGS, 8'h02);
      rdc(OFF_FLAGS, 8'h75, "unrel clr");
      $display("test status done");
      pps_link_model_inst.wr(OFF_CTRL, 8'h06);
      repeat (4) @(posedge clk);
      rdc(OFF_FLAGS, 8'h75, "deep only");
      `CHK("tone on", 1'b1, tone[0])
      pps_link_model_inst.wr(OFF_CTRL, 8'h07);
      repeat (4) @(posedge clk);
      rdc(OFF_FLAGS, 8'h11, "deep dis");
      `CHK("tone off", 1'b0, tone[0])
      `CHK("active", 1'b0, act[0])
      $display("test disable done");
      pps_link_model_inst.sel_page(PAGE_VENDOR);
      @(negedge clk);
      `CHK("vpage", 1'b1, vpage)
      rdc(OFF_VENDOR, VENDOR_ID_BYTE, "vendor");
      rdc(OFF_SPEED, 8'h00, "hidden");
      pps_link_model_inst.sel_page(PAGE_PORT);
      @(negedge clk);
      `CHK("vpage off", 1'b0, vpage)
      $display("test page done");
      @(posedge clk);
      rstn <= 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rdc(OFF_CTRL, 8'h00, "ctrl rst");
      rdc(OFF_FLAGS, 8'h51, "con rst");
      $display("test second reset done");
      wrap_up();
   end
endmodule // phy_port_status_fields_bench
